/* design/csf_skip_core.sv */
// Program counter sequencer with conditional skip on carry, zero and non-zero
//
// Functional notes
// - Carry set skips operand-count following instructions.
// - Zero skip when non-zero flag is 0.
// - Non-zero skip when non-zero flag is 1.
// - Skip count operand accepts only one to three.
// - One cycle plus one per skipped instruction.
`timescale 1ns/1ps
`include "csf_params.svh"

module csf_skip_core
   import csf_pkg::*;
(
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   // Program memory read port, data is the byte at pc_r
   input  wire logic [7:0]           prog_data,
   output logic      [`CSF_PC_W-1:0] pc_r,
   // Status flags from the ALU, same clock
   input  wire logic                 carry_flag,
   input  wire logic                 nonzero_flag,
   // Hold from the execution units
   input  wire logic                 core_stall,
   // Issue to the execution units
   output logic                      exec_valid_r,
   output logic      [7:0]           exec_opcode_r,
   // Skip walk in progress
   output logic                      skip_busy_r
);

   // Sequencer state
   csf_state_t           state_r;
   csf_state_t           state_nxt;
   logic [1:0]           remain_r;
   logic [1:0]           remain_nxt;
   logic [`CSF_PC_W-1:0] pc_nxt;
   logic                 exec_valid_nxt;
   logic [7:0]           exec_opcode_nxt;
   logic                 skip_busy_nxt;

   // Decoded fields of the byte at pc_r
   logic [2:0]           cur_len;
   logic                 is_skip;
   csf_skip_kind_t       kind;
   logic [1:0]           cnt;
   logic                 cnt_ok;
   logic                 cond;
   logic                 fetch_go;
   logic                 taken;

   // Length of whatever byte sits at the current address
   csf_len_decode u_len (
      .opcode (prog_data),
      .len    (cur_len)
   );

   // Skip opcode fields
   always_comb begin
      kind    = csf_skip_kind_t'(prog_data[`CSF_KIND_HI:`CSF_KIND_LO]);
      cnt     = prog_data[`CSF_CNT_HI:`CSF_CNT_LO];
      is_skip = (prog_data[`CSF_GRP_HI:`CSF_GRP_LO] == `CSF_SKIP_GRP)
                && (kind != SK_NONE);
      // Count zero is not a legal operand and skips nothing
      cnt_ok  = (cnt >= `CSF_CNT_MIN) && (cnt <= `CSF_CNT_MAX);
   end

   // Flag condition of each skip kind
   always_comb begin
      cond = 1'b0;
      unique case (kind)
         SK_NONE:         cond = 1'b0;
         SK_IF_CARRY_SET: cond = carry_flag;
         SK_IF_ZERO:      cond = !nonzero_flag;
         SK_IF_NONZERO:   cond = nonzero_flag;
      endcase
   end

   // Fetch cycle decisions
   always_comb begin
      fetch_go = (state_r == ST_FETCH) && !core_stall;
      taken    = fetch_go && is_skip && cond && cnt_ok;
   end

   // Next-state logic; skips never issue, so no unit can touch a flag
   always_comb begin
      state_nxt       = state_r;
      pc_nxt          = pc_r;
      remain_nxt      = remain_r;
      exec_valid_nxt  = 1'b0;
      exec_opcode_nxt = exec_opcode_r;
      skip_busy_nxt   = 1'b0;
      unique case (state_r)
         ST_FETCH: begin
            if (fetch_go) begin
               if (is_skip) begin
                  // Skip opcode is a single byte
                  pc_nxt = pc_r + `CSF_PC_ONE;
                  if (taken) begin
                     state_nxt     = ST_SKIP;
                     remain_nxt    = cnt;
                     skip_busy_nxt = 1'b1;
                  end
               end else begin
                  // Ordinary instruction goes to the execution units
                  pc_nxt          = pc_r + {{(`CSF_PC_W-3){1'b0}}, cur_len};
                  exec_valid_nxt  = 1'b1;
                  exec_opcode_nxt = prog_data;
               end
            end
         end
         ST_SKIP: begin
            // One skipped instruction per cycle; stalls do not apply here
            pc_nxt     = pc_r + {{(`CSF_PC_W-3){1'b0}}, cur_len};
            remain_nxt = remain_r - 2'h1;
            if (remain_r == 2'h1) begin
               state_nxt = ST_FETCH;
            end else begin
               skip_busy_nxt = 1'b1;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_r       <= ST_FETCH;
         pc_r          <= `CSF_PC_RESET;
         remain_r      <= 2'h0;
         exec_valid_r  <= 1'b0;
         exec_opcode_r <= 8'h00;
         skip_busy_r   <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         pc_r          <= pc_nxt;
         remain_r      <= remain_nxt;
         exec_valid_r  <= exec_valid_nxt;
         exec_opcode_r <= exec_opcode_nxt;
         skip_busy_r   <= skip_busy_nxt;
      end
   end

   // Checks on the skip sequencing
   default clocking chk_cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // Carry set with a legal count enters the walk with that count
   chk_carry_taken: assert property (
      (fetch_go && is_skip && kind == SK_IF_CARRY_SET && cnt_ok && carry_flag)
      |=> (state_r == ST_SKIP) && (remain_r == $past(cnt))
          && (pc_r == $past(pc_r) + `CSF_PC_ONE))
      else $error("carry skip not taken");

   // Carry clear moves to the next instruction
   chk_carry_clear: assert property (
      (fetch_go && is_skip && kind == SK_IF_CARRY_SET && !carry_flag)
      |=> (state_r == ST_FETCH) && !skip_busy_r
          && (pc_r == $past(pc_r) + `CSF_PC_ONE))
      else $error("carry skip taken with carry clear");

   // Zero skip follows the inverted non-zero flag
   chk_zero_skip: assert property (
      (fetch_go && is_skip && kind == SK_IF_ZERO && cnt_ok)
      |=> (skip_busy_r == !$past(nonzero_flag)))
      else $error("zero skip decision wrong");

   // Non-zero skip follows the non-zero flag
   chk_nonzero_skip: assert property (
      (fetch_go && is_skip && kind == SK_IF_NONZERO && cnt_ok)
      |=> (skip_busy_r == $past(nonzero_flag)))
      else $error("non-zero skip decision wrong");

   // A zero count skips nothing
   chk_count_zero: assert property (
      (fetch_go && is_skip && cnt == 2'h0)
      |=> (state_r == ST_FETCH) && (pc_r == $past(pc_r) + `CSF_PC_ONE))
      else $error("zero count started a skip");

   // One skipped instruction costs one extra cycle
   chk_cycles_one: assert property (
      (taken && cnt == 2'h1) |=> skip_busy_r ##1 (!skip_busy_r && state_r == ST_FETCH))
      else $error("skip of one took wrong cycles");

   // Two skipped instructions cost two extra cycles
   chk_cycles_two: assert property (
      (taken && cnt == 2'h2) |=> skip_busy_r [*2] ##1 (!skip_busy_r && state_r == ST_FETCH))
      else $error("skip of two took wrong cycles");

   // Three skipped instructions cost three extra cycles
   chk_cycles_three: assert property (
      (taken && cnt == 2'h3) |=> skip_busy_r [*3] ##1 (!skip_busy_r && state_r == ST_FETCH))
      else $error("skip of three took wrong cycles");

   // Each walk cycle steps over one whole instruction
   chk_walk_step: assert property (
      (state_r == ST_SKIP) |=> (pc_r == $past(pc_r) + {{(`CSF_PC_W-3){1'b0}}, $past(cur_len)}))
      else $error("skip walk step length wrong");

   // Any taken skip, whatever its flag, enters the walk with its own count
   chk_walk_entry: assert property (
      taken |=> (state_r == ST_SKIP) && skip_busy_r && (remain_r == $past(cnt))
                && (pc_r == $past(pc_r) + `CSF_PC_ONE))
      else $error("taken skip did not enter the walk");

   // Walk stays busy while more than one instruction is left to pass
   chk_walk_continue: assert property (
      (state_r == ST_SKIP && remain_r != 2'h1) |=> (state_r == ST_SKIP) && skip_busy_r)
      else $error("skip walk ended early");

   // Walk returns to fetch right after its last skipped instruction
   chk_walk_end: assert property (
      (state_r == ST_SKIP && remain_r == 2'h1) |=> (state_r == ST_FETCH) && !skip_busy_r)
      else $error("skip walk ran too long");

   // Every skip opcode, taken or not, moves the program counter by one byte
   chk_skip_one_byte: assert property (
      (fetch_go && is_skip) |=> (pc_r == $past(pc_r) + `CSF_PC_ONE))
      else $error("skip opcode length not one byte");

   // Skips and skipped bytes are never issued, so flags stay put
   chk_no_issue: assert property (
      ((fetch_go && is_skip) || state_r == ST_SKIP) |=> !exec_valid_r)
      else $error("skip issued an instruction");

endmodule : csf_skip_core

/* design/csf_params.svh */
// Constants for the conditional skip-on-flag sequencer
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// Program counter width and reset value
`define CSF_PC_W        12
`define CSF_PC_RESET    12'h000
`define CSF_PC_ONE      12'h001

// Opcode byte layout: [7:6] extra bytes, [3:2] skip kind, [1:0] skip count
`define CSF_LEN_HI      7
`define CSF_LEN_LO      6
`define CSF_GRP_HI      7
`define CSF_GRP_LO      4
`define CSF_KIND_HI     3
`define CSF_KIND_LO     2
`define CSF_CNT_HI      1
`define CSF_CNT_LO      0

// Opcode group that holds the single-byte skips
`define CSF_SKIP_GRP    4'h0

// Skip count limits and the base cost of one skip instruction
`define CSF_CNT_MIN     2'h1
`define CSF_CNT_MAX     2'h3
`define CSF_CYC_BASE    1

`endif

/* design/csf_pkg.sv */
// Types shared by the conditional skip-on-flag sequencer
package csf_pkg;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_FETCH = 2'b01,
      ST_SKIP  = 2'b10
   } csf_state_t;

   // Skip kind field of a skip opcode
   typedef enum logic [1:0] {
      SK_NONE           = 2'b00,
      SK_IF_CARRY_SET   = 2'b01,
      SK_IF_ZERO        = 2'b10,
      SK_IF_NONZERO     = 2'b11
   } csf_skip_kind_t;

endpackage : csf_pkg

/* design/csf_len_decode.sv */
// Byte length decoder for one opcode byte
`timescale 1ns/1ps
`include "csf_params.svh"

module csf_len_decode
   import csf_pkg::*;
(
   // Opcode byte in
   input  wire logic [7:0] opcode,
   // Total instruction length in bytes, 1 to 4
   output logic      [2:0] len
);

   // Leading byte carries the count of extra operand bytes
   always_comb begin
      len = {1'b0, opcode[`CSF_LEN_HI:`CSF_LEN_LO]} + 3'h1;
   end

endmodule : csf_len_decode

/* verif/csf_skip_core_tb.sv */
// Self-checking bench for the conditional skip-on-flag sequencer
`timescale 1ns/1ps
`include "csf_params.svh"

module csf_skip_core_tb
   import csf_pkg::*;
;

   // Clock, reset and program memory
   logic                 ref_clk      = 1'b0;
   logic                 reset        = 1'b1;
   logic [7:0]           mem [0:4095];
   logic [7:0]           prog_data;
   // Flags, hold and design outputs
   logic                 carry_flag   = 1'b0;
   logic                 nonzero_flag = 1'b0;
   logic                 core_stall   = 1'b0;
   logic [`CSF_PC_W-1:0] pc_r;
   logic                 exec_valid_r;
   logic [7:0]           exec_opcode_r;
   logic                 skip_busy_r;
   int                   fails        = 0;
   int                   total_checks = 0;

   // Free-running core clock, 25 ns period
   always #12.5 ref_clk = ~ref_clk;

   // Program memory answers in the same cycle
   assign prog_data = mem[pc_r];

   csf_skip_core i_csf_skip_core (
      .ref_clk      (ref_clk),
      .reset        (reset),
      .prog_data    (prog_data),
      .pc_r         (pc_r),
      .carry_flag   (carry_flag),
      .nonzero_flag (nonzero_flag),
      .core_stall   (core_stall),
      .exec_valid_r (exec_valid_r),
      .exec_opcode_r(exec_opcode_r),
      .skip_busy_r  (skip_busy_r)
   );

   // Compare one value and count it
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Print the counts and the verdict, then stop
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   // One skip at the held pc; skipped lengths are 2, 1, 3 so a wrong sum lands elsewhere
   task automatic run_skip(input csf_skip_kind_t kind, input logic [1:0] cnt, input logic t);
      logic [11:0] p;
      logic [7:0]  exp_op;
      logic [11:0] exp_pc;
      logic        taken;
      int          n;
      int          busy;
      n = 0;
      busy = 0;
      @(negedge ref_clk);
      core_stall = 1'b1;
      @(negedge ref_clk);
      p = pc_r;
      @(negedge ref_clk);
      chk("stalled pc", p, pc_r);
      mem[p] = {4'h0, kind, cnt};
      mem[p + 1] = 8'h50;
      mem[p + 2] = 8'hFF;
      mem[p + 3] = 8'h10;
      mem[p + 4] = 8'h90;
      mem[p + 5] = 8'hFF;
      mem[p + 6] = 8'hFF;
      mem[p + 7] = 8'h20;
      // The unused flag is set so that a wrong flag choice flips the outcome
      carry_flag = (kind == SK_IF_CARRY_SET) ? t : ~t;
      nonzero_flag = (kind == SK_IF_NONZERO) ? t : ~t;
      taken = t && (cnt != 2'h0);
      exp_op = !taken ? 8'h50 : (cnt == 2'h1) ? 8'h10 : (cnt == 2'h2) ? 8'h90 : 8'h20;
      // Skip byte plus skipped lengths plus the issued length
      exp_pc = !taken ? 12'h003 : (cnt == 2'h1) ? 12'h004 : (cnt == 2'h2) ? 12'h007 : 12'h008;
      exp_pc = p + exp_pc;
      core_stall = 1'b0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
         if (skip_busy_r === 1'b1) busy++;
      end while (n < 12 && exec_valid_r !== 1'b1);
      chk("issued opcode", {4'h0, exp_op}, {4'h0, exec_opcode_r});
      chk("edges to issue", taken ? 12'(cnt + 2) : 12'h002, 12'(n));
      chk("walk cycles", taken ? 12'(cnt) : 12'h000, 12'(busy));
      chk("pc after issue", exp_pc, pc_r);
      $display("skip kind %0d count %0d flag %0d done", kind, cnt, t);
   endtask : run_skip

   // Main sequence: every kind except SK_NONE, every count with flag true, counts one to three with flag false
   initial begin
      for (int a = 0; a < 4096; a++) mem[a] = 8'h00;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("pc in reset", `CSF_PC_RESET, pc_r);
      reset = 1'b0;
      for (int k = 1; k <= 3; k++) begin
         for (int c = 0; c <= 3; c++) begin
            run_skip(csf_skip_kind_t'(k), 2'(c), 1'b1);
            if (c != 0) run_skip(csf_skip_kind_t'(k), 2'(c), 1'b0);
         end
      end
      close_out();
   end

   // Watchdog well beyond the hundred or so cycles the tests need
   initial begin
      #50000;
      fails++;
      $display("watchdog expired");
      close_out();
   end

endmodule : csf_skip_core_tb
